//--- rtl/ebc_blanking_counter.sv
// Earth blanking angle counter: degree count, decodes and sensor masking
// Notes on behaviour
// - Velocity pulses are counted in a nine-bit counter that can hold up to 511.
// - Each counted velocity pulse stands for one degree, 360 per revolution.
// - The count returns to zero on the 360th pulse or a sky-to-earth horizon pulse.
// - Two decodes flag when the count reaches 200 and when it reaches 330.
// - In fine gain mode all threshold outputs are masked over counts 0 to 329.
// - In coarse gain mode threshold outputs are masked only over counts 0 to 199.
// - The 330 deblanking pulse is still produced in coarse mode as a backup.
// - Ground-commanded selects route either pitch sensor into either loop.
// - In fine mode the 200 decode also gives a backup reset to the error latches.
`timescale 1ns/1ps
`default_nettype none
module ebc_blanking_counter
#(
	parameter int NUM_LOOPS = 2
)
(
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	// Encoder and horizon pulses
	input  wire logic                 velPulse,
	input  wire logic                 horizonPulse,
	// Gain mode, 1 = coarse
	input  wire logic                 coarseMode,
	// Sensor routing, one bit per loop, and one threshold bit per sensor
	input  wire logic [NUM_LOOPS-1:0] sensorSel,
	input  wire logic                 sensorAThresh,
	input  wire logic                 sensorBThresh,
	// Results
	output var  logic [8:0]           angleCount,
	output var  logic                 decode200,
	output var  logic                 decode330,
	output var  logic                 blankActive,
	output var  logic [NUM_LOOPS-1:0] loopHorizon,
	output var  logic                 pwmBackupReset
);
	logic                 velRise;
	logic                 horRise;
	logic [8:0]           count_reg;
	logic [8:0]           count_next;
	logic [8:0]           countInc;
	logic                 hit200;
	logic                 hit330;
	logic                 blank_next;
	logic [NUM_LOOPS-1:0] loop_next;
	logic                 backup_next;

	ebc_edge_detect u_vel
	(
		.mclk  (mclk),
		.rst_n (rst_n),
		.level (velPulse),
		.rise  (velRise)
	);

	ebc_edge_detect u_hor
	(
		.mclk  (mclk),
		.rst_n (rst_n),
		.level (horizonPulse),
		.rise  (horRise)
	);

	assign countInc = count_reg + ebc_pkg::CNT_ONE;
	// Horizon reset first so a coincident pulse never leaks one degree
	assign count_next = horRise ? ebc_pkg::CNT_ZERO :
		(!velRise) ? count_reg :
		(countInc == ebc_pkg::REV_COUNT) ? ebc_pkg::CNT_ZERO : countInc;
	assign hit200 = (count_next == ebc_pkg::COARSE_ANGLE);
	assign hit330 = (count_next == ebc_pkg::FINE_ANGLE);
	// Mask window based on the new count so outputs stay in step with angleCount
	assign blank_next = coarseMode ? (count_next < ebc_pkg::COARSE_ANGLE)
		: (count_next < ebc_pkg::FINE_ANGLE);
	assign backup_next = hit200 && velRise && !coarseMode;

	genvar g;
	generate
		for (g = 0; g < NUM_LOOPS; g++)
		begin : g_loop
			assign loop_next[g] = ~blank_next &
				(sensorSel[g] ? sensorBThresh : sensorAThresh);
		end
	endgenerate

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_reg      <= ebc_pkg::CNT_ZERO;
			decode200      <= 1'b0;
			decode330      <= 1'b0;
			blankActive    <= 1'b1;
			loopHorizon    <= '0;
			pwmBackupReset <= 1'b0;
		end
		else
		begin
			count_reg      <= count_next;
			decode200      <= hit200 && velRise;
			decode330      <= hit330 && velRise;
			blankActive    <= blank_next;
			loopHorizon    <= loop_next;
			pwmBackupReset <= backup_next;
		end
	end

	assign angleCount = count_reg;

	// Counts one step short of the wrap and of each decode, used by the checks below
	logic [8:0] lastDeg;
	logic [8:0] pre200;
	logic [8:0] pre330;
	assign lastDeg = ebc_pkg::REV_COUNT - ebc_pkg::CNT_ONE;
	assign pre200  = ebc_pkg::COARSE_ANGLE - ebc_pkg::CNT_ONE;
	assign pre330  = ebc_pkg::FINE_ANGLE - ebc_pkg::CNT_ONE;

	property p_wrap;
		@(posedge mclk) disable iff (!rst_n)
		(velRise && !horRise && count_reg == lastDeg) |=> count_reg == ebc_pkg::CNT_ZERO;
	endproperty
	a_wrap: assert property (p_wrap) else $error("count did not wrap at 360");

	property p_horizon;
		@(posedge mclk) disable iff (!rst_n)
		horRise |=> count_reg == ebc_pkg::CNT_ZERO;
	endproperty
	a_horizon: assert property (p_horizon) else $error("horizon did not clear count");

	property p_step;
		@(posedge mclk) disable iff (!rst_n)
		(velRise && !horRise && count_reg < lastDeg)
			|=> count_reg == $past(count_reg) + ebc_pkg::CNT_ONE;
	endproperty
	a_step: assert property (p_step) else $error("count did not step by one");

	property p_hold;
		@(posedge mclk) disable iff (!rst_n)
		(!velRise && !horRise) |=> $stable(count_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved without a pulse");

	property p_range;
		@(posedge mclk) disable iff (!rst_n)
		count_reg < ebc_pkg::REV_COUNT;
	endproperty
	a_range: assert property (p_range) else $error("count beyond one revolution");

	property p_dec330;
		@(posedge mclk) disable iff (!rst_n)
		decode330 |-> count_reg == ebc_pkg::FINE_ANGLE;
	endproperty
	a_dec330: assert property (p_dec330) else $error("330 decode at wrong count");

	property p_dec200;
		@(posedge mclk) disable iff (!rst_n)
		decode200 |-> count_reg == ebc_pkg::COARSE_ANGLE;
	endproperty
	a_dec200: assert property (p_dec200) else $error("200 decode at wrong count");

	property p_fine;
		@(posedge mclk) disable iff (!rst_n)
		!$past(coarseMode) |-> blankActive == (count_reg < ebc_pkg::FINE_ANGLE);
	endproperty
	a_fine: assert property (p_fine) else $error("fine mask window wrong");

	property p_coarse;
		@(posedge mclk) disable iff (!rst_n)
		$past(coarseMode) |-> blankActive == (count_reg < ebc_pkg::COARSE_ANGLE);
	endproperty
	a_coarse: assert property (p_coarse) else $error("coarse mask window wrong");

	property p_mask;
		@(posedge mclk) disable iff (!rst_n)
		blankActive |-> loopHorizon == '0;
	endproperty
	a_mask: assert property (p_mask) else $error("threshold passed while masked");

	property p_backup;
		@(posedge mclk) disable iff (!rst_n)
		pwmBackupReset |-> decode200 && !$past(coarseMode);
	endproperty
	a_backup: assert property (p_backup) else $error("backup reset outside fine 200");

	// Each decode must fire on the very edge that lands on its count
	property p_set200;
		@(posedge mclk) disable iff (!rst_n)
		(velRise && !horRise && count_reg == pre200) |=> decode200;
	endproperty
	a_set200: assert property (p_set200) else $error("200 decode missed");

	property p_set330;
		@(posedge mclk) disable iff (!rst_n)
		(velRise && !horRise && count_reg == pre330) |=> decode330;
	endproperty
	a_set330: assert property (p_set330) else $error("330 decode missed");

	property p_backup_set;
		@(posedge mclk) disable iff (!rst_n)
		(velRise && !horRise && !coarseMode && count_reg == pre200) |=> pwmBackupReset;
	endproperty
	a_backup_set: assert property (p_backup_set) else $error("backup reset missed");

	property p_pulse330;
		@(posedge mclk) disable iff (!rst_n)
		decode330 |=> !decode330;
	endproperty
	a_pulse330: assert property (p_pulse330) else $error("330 decode held too long");

	generate
		for (g = 0; g < NUM_LOOPS; g++)
		begin : g_route_chk
			property p_route;
				@(posedge mclk) disable iff (!rst_n)
				!blankActive |-> loopHorizon[g] ==
					($past(sensorSel[g]) ? $past(sensorBThresh) : $past(sensorAThresh));
			endproperty
			a_route: assert property (p_route) else $error("loop not fed by its sensor");
		end
	endgenerate

	c_wrap:   cover property (@(posedge mclk) disable iff (!rst_n)
		velRise && count_reg == lastDeg);
	c_hor:    cover property (@(posedge mclk) disable iff (!rst_n)
		horRise && count_reg > ebc_pkg::COARSE_ANGLE);
	c_coarse: cover property (@(posedge mclk) disable iff (!rst_n)
		decode330 && $past(coarseMode));
	c_pass:   cover property (@(posedge mclk) disable iff (!rst_n) loopHorizon != '0);
	c_clash:  cover property (@(posedge mclk) disable iff (!rst_n) velRise && horRise);
endmodule // ebc_blanking_counter
`default_nettype wire

//--- rtl/ebc_edge_detect.sv
// Rising edge detector for synchronous pulse inputs
`timescale 1ns/1ps
`default_nettype none
module ebc_edge_detect
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	// Level in, pulse out
	input  wire logic level,
	output var  logic rise
);
	logic levelReg;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			levelReg <= 1'b0;
		else
			levelReg <= level;
	end

	assign rise = level & ~levelReg;
endmodule // ebc_edge_detect
`default_nettype wire

//--- rtl/ebc_pkg.sv
// Package: constants for the earth blanking angle counter
`default_nettype none
package ebc_pkg;
	localparam int          CNT_W        = 9;
	localparam logic [8:0]  CNT_ZERO     = 9'h000;
	localparam logic [8:0]  CNT_ONE      = 9'h001;
	localparam logic [8:0]  REV_COUNT    = 9'h168; // 360 pulses per revolution
	localparam logic [8:0]  COARSE_ANGLE = 9'h0c8; // 200 degrees
	localparam logic [8:0]  FINE_ANGLE   = 9'h14a; // 330 degrees
	typedef enum logic {EBC_FINE, EBC_COARSE} ebc_gain_t;
endpackage : ebc_pkg
`default_nettype wire

//--- verification/earth_blanking_angle_counter_tb.sv
// Testbench for the earth blanking angle counter
`timescale 1ns/1ps
`default_nettype none
module earth_blanking_angle_counter_tb;
	logic       mclk = 1'b0;
	logic       rst_n = 1'b0;
	logic       coarseMode = 1'b0;
	logic [1:0] sensorSel = 2'b10;
	logic       sensorAThresh = 1'b1;
	logic       sensorBThresh = 1'b0;
	logic       velPulse;
	logic       horizonPulse;
	logic [8:0] angleCount;
	logic       decode200;
	logic       decode330;
	logic       blankActive;
	logic       pwmBackupReset;
	logic [1:0] loopHorizon;
	int         n_mismatch = 0;
	int         checks_done = 0;
	always #2 mclk = ~mclk;
	ebc_sensor_model u_model (.mclk, .velPulse, .horizonPulse, .indexPulse());
	ebc_blanking_counter u_dut (.mclk, .rst_n, .velPulse, .horizonPulse, .coarseMode,
		.sensorSel, .sensorAThresh, .sensorBThresh, .angleCount, .decode200,
		.decode330, .blankActive, .loopHorizon, .pwmBackupReset);
	task automatic check(input logic [8:0] seen, input logic [8:0] expected);
		checks_done++;
		if (seen !== expected)
		begin
			n_mismatch++;
			$display("BAD %0t saw %h want %h", $time, seen, expected);
		end
	endtask
	task automatic fineRev;
		u_model.step(200, 1'b1, 1'b0);
		check({8'h00, decode200}, 9'h001);
		check({8'h00, pwmBackupReset}, 9'h001);
		check({8'h00, blankActive}, 9'h001);
		u_model.step(130, 1'b1, 1'b0);
		check({8'h00, decode330}, 9'h001);
		check({8'h00, blankActive}, 9'h000);
		@(posedge mclk);
		#1 check({7'h00, loopHorizon}, 9'h001);
		check({8'h00, decode330}, 9'h000);
		u_model.step(29, 1'b1, 1'b0);
		check(angleCount, 9'h167);
		u_model.step(1, 1'b1, 1'b0);
		check(angleCount, 9'h000);
		check({8'h00, blankActive}, 9'h001);
	endtask
	task automatic coarseRev;
		coarseMode = 1'b1;
		sensorSel = 2'b01;
		u_model.step(200, 1'b1, 1'b0);
		check({8'h00, decode200}, 9'h001);
		check({8'h00, blankActive}, 9'h000);
		check({8'h00, pwmBackupReset}, 9'h000);
		@(posedge mclk);
		#1 check({7'h00, loopHorizon}, 9'h002);
		u_model.step(130, 1'b1, 1'b0);
		check({8'h00, decode330}, 9'h001);
		u_model.step(1, 1'b0, 1'b1);
		check(angleCount, 9'h000);
	endtask
	// Horizon edge landing with a velocity edge must win
	task automatic clash;
		u_model.step(5, 1'b1, 1'b0);
		u_model.step(1, 1'b1, 1'b1);
		check(angleCount, 9'h000);
		u_model.step(1, 1'b1, 1'b0);
		check(angleCount, 9'h001);
	endtask
	// Reset in mid-revolution drops the count and closes the loops again
	task automatic midReset;
		u_model.step(201, 1'b1, 1'b0);
		check({7'h00, loopHorizon}, 9'h002);
		rst_n = 1'b0;
		#1 check(angleCount, 9'h000);
		check({8'h00, blankActive}, 9'h001);
		check({7'h00, loopHorizon}, 9'h000);
		repeat (2) @(posedge mclk);
		#1 rst_n = 1'b1;
		u_model.step(1, 1'b1, 1'b0);
		check(angleCount, 9'h001);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge mclk);
		#1 rst_n = 1'b1;
		check(angleCount, 9'h000);
		check({8'h00, blankActive}, 9'h001);
		fineRev();
		coarseRev();
		clash();
		midReset();
		summarize();
	end
endmodule // earth_blanking_angle_counter_tb
`default_nettype wire

//--- verification/ebc_sensor_model.sv
// Encoder and horizon sensor model
`timescale 1ns/1ps
`default_nettype none
module ebc_sensor_model
(
	// Clock
	input  wire logic mclk,
	// Pulses
	output var  logic velPulse,
	output var  logic horizonPulse,
	output var  logic indexPulse
);
	int degCnt = 0;
	initial
	begin
		velPulse = 1'b0;
		horizonPulse = 1'b0;
		indexPulse = 1'b0;
	end
	// High one cycle, low one cycle: fastest legal rate
	task automatic step(input int n, input logic v, input logic h);
		repeat (n)
		begin
			@(posedge mclk);
			#1 velPulse = v;
			horizonPulse = h;
			indexPulse = v && degCnt == 0;
			degCnt = v ? (degCnt + 1) % 360 : degCnt;
			@(posedge mclk);
			#1 velPulse = 1'b0;
			horizonPulse = 1'b0;
			indexPulse = 1'b0;
		end
	endtask
endmodule // ebc_sensor_model
`default_nettype wire
